// File: host_interrupt_aggregator.sv
// host interrupt aggregator: eight event flags, mask, enable, pin drive
// assumes a classic wishbone master on sys_clk and event pulses on sys_clk
//
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "irq_agg_regs.svh"
module host_interrupt_aggregator #(
  parameter int NUM_SRC = 8
) (
  // clock, reset, enable
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire logic                 clk_en,
  // register bus
  input  wire irq_agg_pkg::wb_req_s wb_req,
  output irq_agg_pkg::wb_rsp_s      wb_rsp,
  // internal event sources
  input  wire logic                 touch_conversion_done,
  input  wire logic                 command_queue_flag,
  input  wire logic                 command_queue_empty,
  input  wire logic                 playback_ended,
  input  wire logic                 sound_ended,
  input  wire logic                 tag_changed,
  input  wire logic                 touch_detected,
  input  wire logic                 list_swapped,
  // interrupt pin
  output irq_agg_pkg::pin_drive_s   irq_n_pin
);
  import irq_agg_pkg::*;

  // ****************
  // declarations
  // ****************
  logic [NUM_SRC-1:0] events;
  logic [NUM_SRC-1:0] flags;
  logic [NUM_SRC-1:0] mask_q;
  logic               global_en_q;
  logic               push_pull_q;
  bus_state_e         bus_q;
  logic [31:0]        rd_d;
  logic [31:0]        rd_q;
  logic               req;
  logic               wr;
  logic               flag_read;
  logic               pending;

  // ****************
  // source mapping
  // ****************
  always_comb begin
    events                  = '0;
    events[`SRC_TOUCH_CONV] = touch_conversion_done;
    events[`SRC_CMD_FLAG]   = command_queue_flag;
    events[`SRC_CMD_EMPTY]  = command_queue_empty;
    events[`SRC_PLAYBACK]   = playback_ended;
    events[`SRC_SOUND]      = sound_ended;
    events[`SRC_TAG]        = tag_changed;
    events[`SRC_TOUCH]      = touch_detected;
    events[`SRC_SWAP]       = list_swapped;
  end

  // ****************
  // bus decode
  // ****************
  assign req       = wb_req.cyc && wb_req.stb && (bus_q == BUS_IDLE);
  assign wr        = req && wb_req.we && wb_req.sel[0];
  assign flag_read = req && !wb_req.we && (wb_req.adr == `FLAG_LATCH_OFS);

  // ****************
  // flag latches
  // ****************
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_flag
    irq_flag_bit u_flag (
      .sys_clk     (sys_clk),
      .reset       (reset),
      .clk_en      (clk_en),
      .event_pulse (events[i]),
      .read_clear  (flag_read),
      .flag_q      (flags[i])
    );
  end

  // ****************
  // control registers
  // ****************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mask_q      <= `MASK_RESET;
      global_en_q <= `GLOBAL_EN_RESET;
      push_pull_q <= `GPIO_EXT_RESET;
    end else if (clk_en && wr) begin
      unique case (wb_req.adr)
        `MASK_OFS:      mask_q      <= wb_req.dat[NUM_SRC-1:0];
        `GLOBAL_EN_OFS: global_en_q <= wb_req.dat[0];
        `GPIO_EXT_OFS:  push_pull_q <= wb_req.dat[`GPIO_EXT_PP_BIT];
        default: ;
      endcase
    end
  end

  // ****************
  // read mux
  // ****************
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (wb_req.adr)
      `FLAG_LATCH_OFS: rd_d[NUM_SRC-1:0] = flags;
      `MASK_OFS:       rd_d[NUM_SRC-1:0] = mask_q;
      `GLOBAL_EN_OFS:  rd_d[0]           = global_en_q;
      `GPIO_EXT_OFS:   rd_d[0]           = push_pull_q;
      default:         rd_d              = 32'h0000_0000;
    endcase
  end

  // ****************
  // bus handshake
  // ****************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_q <= BUS_IDLE;
      rd_q  <= 32'h0000_0000;
    end else if (clk_en) begin
      unique case (bus_q)
        BUS_IDLE: begin
          if (req) begin
            bus_q <= BUS_ACK;
            rd_q  <= rd_d;
          end
        end
        BUS_ACK: bus_q <= BUS_IDLE;
      endcase
    end
  end

  always_comb begin
    wb_rsp.ack = (bus_q == BUS_ACK);
    wb_rsp.dat = rd_q;
  end

  // ****************
  // line control
  // ****************
  assign pending = |(flags & mask_q);

  irq_line_drive u_line (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .global_en (global_en_q),
    .push_pull (push_pull_q),
    .pending   (pending),
    .line_q    (irq_n_pin)
  );

endmodule : host_interrupt_aggregator

// File: irq_agg_regs.svh
// constants for the host interrupt aggregator
// assumes a 32-bit classic wishbone slave with byte offsets
`ifndef IRQ_AGG_REGS_SVH
`define IRQ_AGG_REGS_SVH

// ****************
// register offsets
// ****************
`define FLAG_LATCH_OFS    8'h00
`define MASK_OFS          8'h04
`define GLOBAL_EN_OFS     8'h08
`define GPIO_EXT_OFS      8'h0C

// ****************
// fields and resets
// ****************
`define GPIO_EXT_PP_BIT   0
`define MASK_RESET        8'hFF
`define GLOBAL_EN_RESET   1'h0
`define GPIO_EXT_RESET    1'h0
`define FLAG_RESET        8'h00
`define SRC_TOUCH_CONV    7
`define SRC_CMD_FLAG      6
`define SRC_CMD_EMPTY     5
`define SRC_PLAYBACK      4
`define SRC_SOUND         3
`define SRC_TAG           2
`define SRC_TOUCH         1
`define SRC_SWAP          0

`endif

// File: irq_agg_pkg.sv
// types for the host interrupt aggregator
// assumes nothing of its surroundings
package irq_agg_pkg;

  // ****************
  // carriers
  // ****************
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;

  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_s;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_e;

endpackage : irq_agg_pkg

// File: irq_flag_bit.sv
// one read-clear flag bit fed by an internal event
// assumes the event is a one-cycle pulse on sys_clk
`timescale 1ns/1ps
module irq_flag_bit (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  // event and clear
  input  wire logic event_pulse,
  input  wire logic read_clear,
  // state
  output logic      flag_q
);
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else if (clk_en) begin
      if (event_pulse) begin
        flag_q <= 1'b1;
      end else if (read_clear) begin
        flag_q <= 1'b0;
      end
    end
  end
endmodule : irq_flag_bit

// File: irq_line_drive.sv
// drives the active-low interrupt line, open-drain or push-pull
// assumes an external pull-up on the line
`timescale 1ns/1ps
module irq_line_drive (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic               clk_en,
  // control
  input  wire logic               global_en,
  input  wire logic               push_pull,
  input  wire logic               pending,
  // pin
  output irq_agg_pkg::pin_drive_s line_q
);
  import irq_agg_pkg::*;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      line_q <= '{o: 1'b1, oe: 1'b0};
    end else if (clk_en) begin
      if (!global_en) begin
        line_q <= '{o: 1'b1, oe: 1'b0};
      end else if (pending) begin
        line_q <= '{o: 1'b0, oe: 1'b1};
      end else begin
        line_q <= '{o: 1'b1, oe: push_pull};
      end
    end
  end
endmodule : irq_line_drive

// File: host_interrupt_aggregator_properties.sv
// checker for the host interrupt aggregator
// assumes a classic wishbone master that holds requests until ack
`timescale 1ns/1ps
`include "irq_agg_regs.svh"
module host_interrupt_aggregator_properties (
  // watched ports
  input wire logic                    sys_clk,
  input wire logic                    reset,
  input wire logic                    clk_en,
  input wire irq_agg_pkg::wb_req_s    wb_req,
  input wire irq_agg_pkg::wb_rsp_s    wb_rsp,
  input wire irq_agg_pkg::pin_drive_s irq_n_pin
);
  import irq_agg_pkg::*;
  logic en_q;
  logic pp_q;
  wire  wr = clk_en && wb_rsp.ack && wb_req.cyc && wb_req.we && wb_req.sel[0];
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      en_q <= 1'b0;
      pp_q <= 1'b0;
    end else if (wr && wb_req.adr == `GLOBAL_EN_OFS) begin
      en_q <= wb_req.dat[0];
    end else if (wr && wb_req.adr == `GPIO_EXT_OFS) begin
      pp_q <= wb_req.dat[0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset || !clk_en);
  sequence s_take;
    wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  endsequence
  AST_ACK_NEXT: assert property (s_take |=> wb_rsp.ack) else $error("ack late");
  AST_ACK_ONE: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack long");
  AST_ACK_CAUSE: assert property (!(wb_req.cyc && wb_req.stb) |=> !wb_rsp.ack) else $error("stray ack");
  AST_UPPER: assert property (wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h000000) else $error("upper bits");
  AST_UNMAPPED: assert property (wb_rsp.ack && !wb_req.we && wb_req.adr > `GPIO_EXT_OFS
    |-> wb_rsp.dat == 32'h00000000) else $error("unmapped data");
  AST_OFF: assert property (!en_q |-> !irq_n_pin.oe) else $error("driven while off");
  AST_OD: assert property (irq_n_pin.oe && !pp_q |-> !irq_n_pin.o) else $error("drove high");
  AST_PP: assert property (en_q && pp_q |-> irq_n_pin.oe) else $error("push-pull idle");
endmodule : host_interrupt_aggregator_properties
bind host_interrupt_aggregator host_interrupt_aggregator_properties chk_u (
  .sys_clk, .reset, .clk_en, .wb_req, .wb_rsp, .irq_n_pin);

// File: host_irq_monitor.sv
// host side view of the interrupt line
// assumes an external pull-up on the line
`timescale 1ns/1ps
module host_irq_monitor (
  // pin from the device
  input wire irq_agg_pkg::pin_drive_s irq_n_pin,
  // resolved line
  output logic                        irq_n_line
);
  import irq_agg_pkg::*;
  assign irq_n_line = irq_n_pin.oe ? irq_n_pin.o : 1'b1;
endmodule : host_irq_monitor

// File: host_interrupt_aggregator_tb_top.sv
// bench for the host interrupt aggregator
// assumes the bound checker and the host monitor
`timescale 1ns/1ps
`include "irq_agg_regs.svh"
module host_interrupt_aggregator_tb_top;
  import irq_agg_pkg::*;
  logic       sys_clk = 1'b0;
  logic       reset = 1'b1;
  logic       clk_en = 1'b1;
  logic [3:0] wsel = 4'hF;
  logic [7:0] ev = 8'h00;
  wb_req_s    req = '0;
  wb_rsp_s    rsp;
  pin_drive_s pin;
  logic       line;
  logic [31:0] rd;
  int         fails = 0;
  int         comparisons = 0;
  always #25 sys_clk = ~sys_clk;
  host_interrupt_aggregator dut_u (.sys_clk, .reset, .clk_en, .wb_req(req), .wb_rsp(rsp),
    .touch_conversion_done(ev[7]), .command_queue_flag(ev[6]), .command_queue_empty(ev[5]),
    .playback_ended(ev[4]), .sound_ended(ev[3]), .tag_changed(ev[2]), .touch_detected(ev[1]),
    .list_swapped(ev[0]), .irq_n_pin(pin));
  host_irq_monitor host_u (.irq_n_pin(pin), .irq_n_line(line));
  // ****
  // tasks
  // ****
  task automatic close_out();
    $display("counts %0d comparisons %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
    comparisons++;
    if (y !== x) begin
      fails++;
      $display("mismatch %s expected %h seen %h", s, x, y);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [7:0] e,
    output logic [31:0] r);
    int n;
    @(posedge sys_clk);
    req <= '{1'b1, 1'b1, w, wsel, a, d};
    ev <= e;
    for (n = 0; n < 20 && rsp.ack !== 1'b1; n++) begin
      @(posedge sys_clk);
      ev <= 8'h00;
    end
    r = rsp.dat;
    req <= '0;
    if (n == 20) begin
      chk("ack", 32'h1, {31'h0, rsp.ack});
      close_out();
    end
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 8'h00, rd);
    @(posedge sys_clk);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input string s);
    xfer(1'b0, a, 32'h0, 8'h00, rd);
    chk(s, x, rd);
    @(posedge sys_clk);
  endtask : rd_chk
  task automatic pulse(input logic [7:0] e);
    @(posedge sys_clk);
    ev <= e;
    @(posedge sys_clk);
    ev <= 8'h00;
    repeat (2) @(posedge sys_clk);
  endtask : pulse
  task automatic t_reset();
    rd_chk(`MASK_OFS, 32'hFF, "mask");
    rd_chk(`GLOBAL_EN_OFS, 32'h0, "enable");
    rd_chk(`GPIO_EXT_OFS, 32'h0, "gpio");
    wr(8'h10, 32'h1);
    rd_chk(8'h10, 32'h0, "unmapped");
    wsel = 4'hE;
    wr(`MASK_OFS, 32'h0);
    wsel = 4'hF;
    rd_chk(`MASK_OFS, 32'hFF, "sel ignored");
    wr(`FLAG_LATCH_OFS, 32'hFF);
    rd_chk(`FLAG_LATCH_OFS, 32'h0, "flag write");
    $display("test reset done");
  endtask : t_reset
  task automatic t_flags();
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      chk("off line", 32'h1, line);
      rd_chk(`FLAG_LATCH_OFS, 32'h1 << i, "flag");
    end
    rd_chk(`FLAG_LATCH_OFS, 32'h0, "cleared");
    $display("test flags done");
  endtask : t_flags
  task automatic t_line();
    wr(`GLOBAL_EN_OFS, 32'h1);
    wr(`MASK_OFS, 32'h01);
    pulse(8'h02);
    chk("masked", 32'h1, line);
    pulse(8'h01);
    chk("asserted", 32'h0, line);
    wr(`GLOBAL_EN_OFS, 32'h0);
    chk("disabled", 32'h1, line);
    wr(`GLOBAL_EN_OFS, 32'h1);
    chk("enabled", 32'h0, line);
    rd_chk(`FLAG_LATCH_OFS, 32'h03, "flags");
    chk("released", 32'h1, line);
    $display("test line done");
  endtask : t_line
  task automatic t_drive();
    wr(`GPIO_EXT_OFS, 32'h1);
    chk("pp high", 32'h1, {pin.oe, pin.o} == 2'b11);
    pulse(8'h01);
    chk("pp low", 32'h0, line);
    wr(`GPIO_EXT_OFS, 32'h0);
    chk("od low", 32'h1, {pin.oe, pin.o} == 2'b10);
    xfer(1'b0, `FLAG_LATCH_OFS, 32'h0, 8'h80, rd);
    chk("race read", 32'h01, rd);
    rd_chk(`FLAG_LATCH_OFS, 32'h80, "kept");
    chk("od off", 32'h0, pin.oe);
    $display("test drive done");
  endtask : t_drive
  task automatic t_freeze();
    @(posedge sys_clk);
    clk_en <= 1'b0;
    pulse(8'h01);
    chk("frozen line", 32'h1, line);
    clk_en <= 1'b1;
    rd_chk(`FLAG_LATCH_OFS, 32'h0, "frozen flag");
    $display("test freeze done");
  endtask : t_freeze
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_flags();
    t_line();
    t_drive();
    t_freeze();
    close_out();
  end
endmodule : host_interrupt_aggregator_tb_top
